// File: core/serial_byte_receiver.sv
// Asynchronous serial byte receiver: start, 8 data LSB first, 1 stop.
// Expects a synchronised, polarity-corrected line (idle high) and a 4 MHz tick.
`timescale 1ns/1ps
module serial_byte_receiver (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic enable_i,
    input wire logic line_i,
    input wire logic [lcd_bridge_pkg::BIT_W-1:0] bit_ticks_i,
    output logic [7:0] data_o,
    output logic valid_o,
    output logic frame_error_o,
    output logic busy_o
);
    lcd_bridge_pkg::rx_phase_type phase;
    logic [lcd_bridge_pkg::BIT_W-1:0] count;
    logic [2:0] bit_index;
    logic [7:0] shift;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= lcd_bridge_pkg::RX_START;
            count <= '0;
            bit_index <= '0;
            shift <= '0;
            data_o <= '0;
            valid_o <= 1'b0;
            frame_error_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            valid_o <= 1'b0;
            frame_error_o <= 1'b0;
            if (tick_i) begin
                if (!busy_o) begin
                    if (enable_i && !line_i) begin
                        busy_o <= 1'b1;
                        phase <= lcd_bridge_pkg::RX_START;
                        count <= bit_ticks_i >> 1;
                    end
                end else if (count != '0) begin
                    count <= count - 1'b1;
                end else begin
                    count <= bit_ticks_i - 1'b1;
                    case (phase)
                        lcd_bridge_pkg::RX_START: begin
                            // Glitch shorter than half a bit is dropped
                            if (line_i) begin
                                busy_o <= 1'b0;
                            end else begin
                                phase <= lcd_bridge_pkg::RX_DATA;
                                bit_index <= '0;
                            end
                        end
                        lcd_bridge_pkg::RX_DATA: begin
                            shift <= {line_i, shift[7:1]};
                            bit_index <= bit_index + 1'b1;
                            if (bit_index == lcd_bridge_pkg::LAST_DATA_BIT) begin
                                phase <= lcd_bridge_pkg::RX_STOP;
                            end
                        end
                        default: begin
                            busy_o <= 1'b0;
                            if (line_i) begin
                                data_o <= shift;
                                valid_o <= 1'b1;
                            end else begin
                                frame_error_o <= 1'b1;
                            end
                        end
                    endcase
                end
            end
        end
    end
endmodule : serial_byte_receiver

// File: core/serial_to_char_lcd_bridge.sv
// Serial to character LCD bridge: receives bytes, interprets control codes,
// drives the LCD in 4-bit write-only mode. Registers on classic Wishbone.
// Assumes straps and serial pin are asynchronous; LCD never read back.
// Functional notes
// - Baud strap low gives 2400 baud, high gives 9600 baud.
// - Polarity strap low inverts the line; high is standard polarity.
// - Bytes arrive on one serial input with no handshake or return path.
// - Each byte goes to the LCD as two nibbles on upper data lines.
// - Device drives enable, register select and read/write lines.
// - All timing derives from one 4 MHz reference tick.
// - Byte after 0xFE goes to the LCD as an instruction.
// - CR and LF ignored; form feed clears; backspace erases backwards.
// - 0xFE then 0xFC drives aux low; 0xFD drives it high; no LCD transfer.
// - Aux output low after reset; cursor homed before first character.
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module serial_to_char_lcd_bridge #(
    parameter int POWERUP_WAIT = lcd_bridge_pkg::POWERUP_TICKS,
    parameter int LONG_WAIT = lcd_bridge_pkg::LONG_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serial_rx_in_i,
    input wire logic baud_select_i,
    input wire logic polarity_select_i,
    output logic lcd_enable_o,
    output logic lcd_register_select_o,
    output logic lcd_read_write_o,
    output logic lcd_nibble_bit0_o,
    output logic lcd_nibble_bit1_o,
    output logic lcd_nibble_bit2_o,
    output logic lcd_nibble_bit3_o,
    output logic aux_out_o
);
    localparam int PINS = 3;
    localparam logic [lcd_bridge_pkg::WAIT_W-1:0] POWERUP_COUNT =
        lcd_bridge_pkg::WAIT_W'(POWERUP_WAIT);
    localparam logic [lcd_bridge_pkg::WAIT_W-1:0] LONG_COUNT =
        lcd_bridge_pkg::WAIT_W'(LONG_WAIT);
    localparam logic [lcd_bridge_pkg::WAIT_W-1:0] SHORT_COUNT =
        lcd_bridge_pkg::WAIT_W'(lcd_bridge_pkg::SHORT_TICKS);

    // Step of an operation: {last, long wait, register select, byte}
    function automatic logic [10:0] op_step(input lcd_bridge_pkg::op_type op,
                                            input logic [2:0] idx, input logic [7:0] data);
        logic [10:0] step;
        step = {3'b100, data};
        case (op)
            lcd_bridge_pkg::OP_INIT: begin
                case (idx)
                    3'h0: step = {3'b000, lcd_bridge_pkg::INS_WAKE_A};
                    3'h1: step = {3'b000, lcd_bridge_pkg::INS_WAKE_B};
                    3'h2: step = {3'b000, lcd_bridge_pkg::INS_FUNCTION};
                    3'h3: step = {3'b000, lcd_bridge_pkg::INS_DISPLAY};
                    3'h4: step = {3'b000, lcd_bridge_pkg::INS_ENTRY};
                    default: step = {3'b110, lcd_bridge_pkg::INS_CLEAR};
                endcase
            end
            lcd_bridge_pkg::OP_CHAR: step = {3'b101, data};
            lcd_bridge_pkg::OP_HOMECHAR: step = (idx == 3'h0) ?
                {3'b010, lcd_bridge_pkg::INS_HOME} : {3'b101, data};
            lcd_bridge_pkg::OP_CLEAR: step = {3'b110, lcd_bridge_pkg::INS_CLEAR};
            lcd_bridge_pkg::OP_BACKSPACE: begin
                case (idx)
                    3'h0: step = {3'b000, lcd_bridge_pkg::INS_CURSOR_LEFT};
                    3'h1: step = {3'b001, lcd_bridge_pkg::CHAR_BLANK};
                    default: step = {3'b100, lcd_bridge_pkg::INS_CURSOR_LEFT};
                endcase
            end
            default: step = {1'b1, data < lcd_bridge_pkg::INS_SLOW_LIMIT, 1'b0, data};
        endcase
        return step;
    endfunction : op_step

    logic [PINS-1:0] pin_meta;
    logic [PINS-1:0] pin_sync;
    logic [2:0] div_count;
    logic tick;
    logic baud_fast;
    logic pol_std;
    logic rx_line;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_ferr;
    logic rx_busy;
    logic rx_enable;
    logic [7:0] fifo_mem [lcd_bridge_pkg::FIFO_DEPTH];
    logic fifo_wr_ptr;
    logic fifo_rd_ptr;
    logic [1:0] fifo_count;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic proc_ready;
    logic overrun;
    logic frame_err;
    logic [7:0] last_byte;
    lcd_bridge_pkg::state_type state;
    lcd_bridge_pkg::op_type op;
    logic [2:0] op_idx;
    logic [7:0] op_data;
    logic [10:0] step;
    logic nib_sel;
    logic [1:0] phase;
    logic [lcd_bridge_pkg::WAIT_W-1:0] wait_cnt;
    logic escape_pending;
    logic homed;
    logic [3:0] nibble;
    logic req;
    logic clr_overrun;
    logic clr_ferr;

    // Pins from outside pass two flops first
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pin_meta[gi] <= 1'b1;
                    pin_sync[gi] <= 1'b1;
                end else begin
                    pin_meta[gi] <= (gi == 0) ? serial_rx_in_i :
                        (gi == 1) ? baud_select_i : polarity_select_i;
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_count <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (div_count == lcd_bridge_pkg::TICK_LAST);
            div_count <= (div_count == lcd_bridge_pkg::TICK_LAST) ? '0 : div_count + 1'b1;
        end
    end

    // straps follow only between frames, never mid-byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_fast <= 1'b0;
            pol_std <= 1'b1;
        end else if (!rx_busy) begin
            baud_fast <= pin_sync[1];
            pol_std <= pin_sync[2];
        end
    end

    assign rx_line = pol_std ? pin_sync[0] : ~pin_sync[0];

    serial_byte_receiver u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .enable_i(rx_enable),
        .line_i(rx_line),
        .bit_ticks_i(baud_fast ? lcd_bridge_pkg::FAST_BIT_TICKS :
            lcd_bridge_pkg::SLOW_BIT_TICKS),
        .data_o(rx_data),
        .valid_o(rx_valid),
        .frame_error_o(rx_ferr),
        .busy_o(rx_busy)
    );

    // Two-entry buffer; serial cannot stall, so a full buffer counts overrun
    assign fifo_in_ready = (fifo_count != 2'(lcd_bridge_pkg::FIFO_DEPTH));
    assign fifo_out_valid = (fifo_count != 2'h0);
    assign proc_ready = (state == lcd_bridge_pkg::ST_IDLE);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fifo_wr_ptr <= 1'b0;
            fifo_rd_ptr <= 1'b0;
            fifo_count <= '0;
        end else begin
            if (rx_valid && fifo_in_ready) begin
                fifo_mem[fifo_wr_ptr] <= rx_data;
                fifo_wr_ptr <= ~fifo_wr_ptr;
            end
            if (fifo_out_valid && proc_ready) begin
                fifo_rd_ptr <= ~fifo_rd_ptr;
            end
            fifo_count <= fifo_count + 2'(rx_valid && fifo_in_ready)
                - 2'(fifo_out_valid && proc_ready);
        end
    end

    assign step = op_step(op, op_idx, op_data);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= lcd_bridge_pkg::ST_POWERUP;
            op <= lcd_bridge_pkg::OP_INIT;
            op_idx <= '0;
            op_data <= '0;
            nib_sel <= 1'b0;
            phase <= '0;
            wait_cnt <= POWERUP_COUNT;
            escape_pending <= 1'b0;
            homed <= 1'b0;
            aux_out_o <= 1'b0;
            lcd_enable_o <= 1'b0;
            lcd_register_select_o <= 1'b0;
            nibble <= '0;
        end else begin
            case (state)
                lcd_bridge_pkg::ST_POWERUP: begin
                    if (tick && wait_cnt != '0) begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end else if (tick) begin
                        op <= lcd_bridge_pkg::OP_INIT;
                        op_idx <= '0;
                        nib_sel <= 1'b0;
                        phase <= '0;
                        state <= lcd_bridge_pkg::ST_SEND;
                    end
                end
                lcd_bridge_pkg::ST_IDLE: begin
                    if (fifo_out_valid) begin
                        op_data <= fifo_mem[fifo_rd_ptr];
                        op_idx <= '0;
                        nib_sel <= 1'b0;
                        phase <= '0;
                        if (escape_pending) begin
                            escape_pending <= 1'b0;
                            if (fifo_mem[fifo_rd_ptr] == lcd_bridge_pkg::CODE_AUX_LOW) begin
                                aux_out_o <= 1'b0;
                            end else if (fifo_mem[fifo_rd_ptr] == lcd_bridge_pkg::CODE_AUX_HIGH) begin
                                aux_out_o <= 1'b1;
                            end else begin
                                op <= lcd_bridge_pkg::OP_CMD;
                                state <= lcd_bridge_pkg::ST_SEND;
                            end
                        end else begin
                            case (fifo_mem[fifo_rd_ptr])
                                lcd_bridge_pkg::CODE_ESCAPE: escape_pending <= 1'b1;
                                lcd_bridge_pkg::CODE_RETURN,
                                lcd_bridge_pkg::CODE_NEWLINE: escape_pending <= 1'b0;
                                lcd_bridge_pkg::CODE_FORMFEED: begin
                                    op <= lcd_bridge_pkg::OP_CLEAR;
                                    homed <= 1'b1;
                                    state <= lcd_bridge_pkg::ST_SEND;
                                end
                                lcd_bridge_pkg::CODE_BACKSPACE: begin
                                    op <= lcd_bridge_pkg::OP_BACKSPACE;
                                    state <= lcd_bridge_pkg::ST_SEND;
                                end
                                default: begin
                                    op <= homed ? lcd_bridge_pkg::OP_CHAR :
                                        lcd_bridge_pkg::OP_HOMECHAR;
                                    homed <= 1'b1;
                                    state <= lcd_bridge_pkg::ST_SEND;
                                end
                            endcase
                        end
                    end
                end
                lcd_bridge_pkg::ST_SEND: begin
                    if (tick) begin
                        phase <= phase + 1'b1;
                        if (phase == 2'h0) begin
                            lcd_register_select_o <= step[8];
                            nibble <= nib_sel ? step[3:0] : step[7:4];
                        end else if (phase == lcd_bridge_pkg::PHASE_LAST) begin
                            phase <= '0;
                            nib_sel <= ~nib_sel;
                            if (nib_sel) begin
                                state <= lcd_bridge_pkg::ST_WAIT;
                                wait_cnt <= step[9] ? LONG_COUNT : SHORT_COUNT;
                            end
                        end
                        lcd_enable_o <= (phase != 2'h0) && (phase != lcd_bridge_pkg::PHASE_LAST);
                    end
                end
                default: begin
                    if (tick && wait_cnt != '0) begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end else if (tick && step[10]) begin
                        state <= lcd_bridge_pkg::ST_IDLE;
                    end else if (tick) begin
                        op_idx <= op_idx + 1'b1;
                        state <= lcd_bridge_pkg::ST_SEND;
                    end
                end
            endcase
        end
    end

    assign lcd_read_write_o = 1'b0;
    assign lcd_nibble_bit0_o = nibble[0];
    assign lcd_nibble_bit1_o = nibble[1];
    assign lcd_nibble_bit2_o = nibble[2];
    assign lcd_nibble_bit3_o = nibble[3];

    // Wishbone slave: ack one cycle after request, write on the ack edge
    assign req = wb_cyc_i && wb_stb_i;
    assign clr_overrun = req && wb_ack_o && wb_we_i && wb_sel_i[0]
        && (wb_adr_i == lcd_bridge_pkg::REG_STATUS) && wb_dat_i[lcd_bridge_pkg::STAT_OVERRUN];
    assign clr_ferr = req && wb_ack_o && wb_we_i && wb_sel_i[0]
        && (wb_adr_i == lcd_bridge_pkg::REG_STATUS) && wb_dat_i[lcd_bridge_pkg::STAT_FRAME_ERR];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            rx_enable <= lcd_bridge_pkg::CTRL_RX_ENABLE_RESET;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
            wb_dat_o <= '0;
            if (req && !wb_ack_o && wb_adr_i == lcd_bridge_pkg::REG_CTRL) begin
                wb_dat_o[lcd_bridge_pkg::CTRL_RX_ENABLE] <= rx_enable;
            end else if (req && !wb_ack_o && wb_adr_i == lcd_bridge_pkg::REG_STATUS) begin
                wb_dat_o[lcd_bridge_pkg::STAT_AUX] <= aux_out_o;
                wb_dat_o[lcd_bridge_pkg::STAT_BUSY] <= !proc_ready || fifo_out_valid;
                wb_dat_o[lcd_bridge_pkg::STAT_OVERRUN] <= overrun;
                wb_dat_o[lcd_bridge_pkg::STAT_FRAME_ERR] <= frame_err;
                wb_dat_o[lcd_bridge_pkg::STAT_BAUD_FAST] <= baud_fast;
                wb_dat_o[lcd_bridge_pkg::STAT_POL_STD] <= pol_std;
                wb_dat_o[lcd_bridge_pkg::STAT_ESCAPE] <= escape_pending;
                wb_dat_o[lcd_bridge_pkg::STAT_LAST_HI:lcd_bridge_pkg::STAT_LAST_LO] <= last_byte;
            end
            if (req && wb_ack_o && wb_we_i && wb_sel_i[0]
                && wb_adr_i == lcd_bridge_pkg::REG_CTRL) begin
                rx_enable <= wb_dat_i[lcd_bridge_pkg::CTRL_RX_ENABLE];
            end
        end
    end

    // Sticky flags: a new event beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overrun <= 1'b0;
            frame_err <= 1'b0;
            last_byte <= '0;
        end else begin
            overrun <= (overrun && !clr_overrun) || (rx_valid && !fifo_in_ready);
            frame_err <= (frame_err && !clr_ferr) || rx_ferr;
            if (rx_valid) begin
                last_byte <= rx_data;
            end
        end
    end
endmodule : serial_to_char_lcd_bridge

// File: dv/lcd_bridge_properties.sv
// Port checker for the serial LCD bridge.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module lcd_bridge_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic lcd_enable_o,
    input wire logic lcd_register_select_o,
    input wire logic lcd_read_write_o,
    input wire logic lcd_nibble_bit0_o,
    input wire logic lcd_nibble_bit1_o,
    input wire logic lcd_nibble_bit2_o,
    input wire logic lcd_nibble_bit3_o,
    input wire logic aux_out_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [4:0] bus;
    assign bus = {lcd_register_select_o, lcd_nibble_bit3_o, lcd_nibble_bit2_o,
        lcd_nibble_bit1_o, lcd_nibble_bit0_o};
    AST_WRITE_ONLY: assert property (!lcd_read_write_o)
        else $error("LCD read line raised");
    AST_RESET_QUIET: assert property ($fell(rst_i) |-> !aux_out_o && !lcd_enable_o)
        else $error("Aux or enable high after reset");
    AST_NIB_HOLD: assert property (lcd_enable_o |-> $stable(bus))
        else $error("Nibble moved during enable");
    AST_NIB_SETUP: assert property ($rose(lcd_enable_o) |-> $past(bus, 4) == bus)
        else $error("Nibble not set up a tick early");
    AST_EN_WIDTH: assert property ($rose(lcd_enable_o) |=>
        lcd_enable_o [*8] ##1 lcd_enable_o ##1 !lcd_enable_o)
        else $error("Enable not two ticks wide");
    AST_EN_GAP: assert property ($fell(lcd_enable_o) |-> !lcd_enable_o [*8])
        else $error("Enable gap too short");
    AST_AUX_QUIET: assert property ($changed(aux_out_o) |-> !lcd_enable_o [*8])
        else $error("LCD strobed on aux command");
    AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o ##1 !wb_ack_o)
        else $error("Ack not a one-cycle answer");
endmodule : lcd_bridge_properties
bind serial_to_char_lcd_bridge lcd_bridge_properties i_props (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .lcd_enable_o, .lcd_register_select_o, .lcd_read_write_o,
    .lcd_nibble_bit0_o, .lcd_nibble_bit1_o, .lcd_nibble_bit2_o, .lcd_nibble_bit3_o,
    .aux_out_o);

// File: dv/serial_host_model.sv
// Host serial transmitter model; no return path.
// Assumes straps are shared with the bridge.
`timescale 1ns/1ps
module serial_host_model (
    input wire logic clk_i,
    input wire logic fast_i,
    input wire logic std_i,
    output logic line_o
);
    logic raw = 1'b1;
    assign line_o = std_i ? raw : ~raw;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        int n;
        f = {1'b1, b, 1'b0};
        n = int'(fast_i ? lcd_bridge_pkg::FAST_BIT_TICKS : lcd_bridge_pkg::SLOW_BIT_TICKS);
        n = n * lcd_bridge_pkg::TICK_DIV;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            raw <= f[i];
            repeat (n - 1) @(posedge clk_i);
        end
    endtask : send
endmodule : serial_host_model

// File: dv/serial_to_char_lcd_bridge_tb.sv
// Bench: bus reads, serial bytes in, LCD transfers captured.
// Assumes short init waits; 9600 baud keeps the run brief.
`timescale 1ns/1ps
module serial_to_char_lcd_bridge_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic baud_select_i = 1'b1;
    logic polarity_select_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, serial_rx_in_i, lcd_enable_o, lcd_register_select_o, lcd_read_write_o;
    logic lcd_nibble_bit0_o, lcd_nibble_bit1_o, lcd_nibble_bit2_o, lcd_nibble_bit3_o, aux_out_o;
    logic [3:0] nib, hi;
    logic half = 1'b0;
    logic [8:0] lq[$];
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    always #25 clk_i = ~clk_i;
    serial_to_char_lcd_bridge #(.POWERUP_WAIT(20), .LONG_WAIT(10)) i_dut (.clk_i, .rst_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .serial_rx_in_i, .baud_select_i, .polarity_select_i, .lcd_enable_o,
        .lcd_register_select_o, .lcd_read_write_o, .lcd_nibble_bit0_o, .lcd_nibble_bit1_o,
        .lcd_nibble_bit2_o, .lcd_nibble_bit3_o, .aux_out_o);
    serial_host_model i_host (.clk_i, .fast_i(baud_select_i), .std_i(polarity_select_i),
        .line_o(serial_rx_in_i));
    assign nib = {lcd_nibble_bit3_o, lcd_nibble_bit2_o, lcd_nibble_bit1_o, lcd_nibble_bit0_o};
    // Pair nibbles at each enable fall
    always @(negedge lcd_enable_o) begin
        if (!half) hi = nib;
        else lq.push_back({lcd_register_select_o, hi, nib});
        half = ~half;
    end
    task automatic conclude();
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 95000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // Waits for ack, no fixed latency assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        check("ctrl", 32'h1, rd);
        wb(1'b0, 8'h10, 32'h0);
        check("unmapped", 32'h0, rd);
        wb(1'b0, 8'h04, 32'h0);
        check("straps", 32'h30, rd & 32'h31);
        // Byte overlaps init to save run time; capture cleared once init is over
        fork
            begin
                repeat (9000) @(posedge clk_i);
                lq.delete();
                half = 1'b0;
            end
            i_host.send(8'h41);
        join
        repeat (1500) @(posedge clk_i);
        check("xfers", 32'h2, 32'(lq.size()));
        check("home", {23'h0, 1'b0, 8'h02}, 32'(lq[0]));
        check("char", {23'h0, 1'b1, 8'h41}, 32'(lq[1]));
        polarity_select_i <= 1'b0;
        repeat (1500) @(posedge clk_i);
        i_host.send(8'hFE);
        i_host.send(8'hFD);
        repeat (500) @(posedge clk_i);
        check("aux", 32'h1, {31'h0, aux_out_o});
        check("no_xfer", 32'h2, 32'(lq.size()));
        wb(1'b0, 8'h04, 32'h0);
        check("status", 32'hFD11, rd & 32'hFF31);
        i_host.send(8'h08);
        repeat (1500) @(posedge clk_i);
        check("bs_count", 32'h5, 32'(lq.size()));
        check("bs_left", {23'h0, 1'b0, lcd_bridge_pkg::INS_CURSOR_LEFT}, 32'(lq[2]));
        check("bs_blank", {23'h0, 1'b1, lcd_bridge_pkg::CHAR_BLANK}, 32'(lq[3]));
        check("bs_back", {23'h0, 1'b0, lcd_bridge_pkg::INS_CURSOR_LEFT}, 32'(lq[4]));
        baud_select_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        wb(1'b0, 8'h04, 32'h0);
        check("slow", 32'h0, rd & 32'h10);
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b0, 8'h00, 32'h0);
        check("ctrl_wr", 32'h0, rd);
        conclude();
    end
endmodule : serial_to_char_lcd_bridge_tb

// File: include/lcd_bridge_pkg.sv
// Constants, types and register map for the serial to character LCD bridge.
// Assumes a single 20 MHz system clock; all timing runs off a 4 MHz tick.
package lcd_bridge_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int REF_HZ = 4_000_000;
    localparam int REF_MHZ = REF_HZ / 1_000_000;
    localparam int TICK_DIV = CLK_HZ / REF_HZ;
    localparam logic [2:0] TICK_LAST = 3'(TICK_DIV - 1);

    localparam int SLOW_BAUD = 2400;
    localparam int FAST_BAUD = 9600;
    localparam int BIT_W = 11;
    localparam logic [BIT_W-1:0] SLOW_BIT_TICKS = BIT_W'((REF_HZ + SLOW_BAUD / 2) / SLOW_BAUD);
    localparam logic [BIT_W-1:0] FAST_BIT_TICKS = BIT_W'((REF_HZ + FAST_BAUD / 2) / FAST_BAUD);
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;

    // Least times round up to whole ticks
    localparam int ENABLE_HIGH_NS = 450;
    localparam int ENABLE_TICKS = (ENABLE_HIGH_NS * REF_MHZ + 999) / 1000;
    localparam logic [1:0] PHASE_LAST = 2'(ENABLE_TICKS + 1);
    localparam int POWERUP_US = 15000;
    localparam int LONG_US = 2000;
    localparam int SHORT_US = 50;
    localparam int POWERUP_TICKS = POWERUP_US * REF_MHZ;
    localparam int LONG_TICKS = LONG_US * REF_MHZ;
    localparam int SHORT_TICKS = SHORT_US * REF_MHZ;
    localparam int WAIT_W = 17;

    localparam logic [7:0] CODE_ESCAPE = 8'hFE;
    localparam logic [7:0] CODE_AUX_LOW = 8'hFC;
    localparam logic [7:0] CODE_AUX_HIGH = 8'hFD;
    localparam logic [7:0] CODE_RETURN = 8'h0D;
    localparam logic [7:0] CODE_NEWLINE = 8'h0A;
    localparam logic [7:0] CODE_FORMFEED = 8'h0C;
    localparam logic [7:0] CODE_BACKSPACE = 8'h08;

    localparam logic [7:0] INS_CLEAR = 8'h01;
    localparam logic [7:0] INS_HOME = 8'h02;
    localparam logic [7:0] INS_SLOW_LIMIT = 8'h04;
    localparam logic [7:0] INS_CURSOR_LEFT = 8'h10;
    localparam logic [7:0] INS_WAKE_A = 8'h33;
    localparam logic [7:0] INS_WAKE_B = 8'h32;
    localparam logic [7:0] INS_FUNCTION = 8'h28;
    localparam logic [7:0] INS_DISPLAY = 8'h0C;
    localparam logic [7:0] INS_ENTRY = 8'h06;
    localparam logic [7:0] CHAR_BLANK = 8'h20;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam int CTRL_RX_ENABLE = 0;
    localparam logic CTRL_RX_ENABLE_RESET = 1'b1;
    localparam int STAT_AUX = 0;
    localparam int STAT_BUSY = 1;
    localparam int STAT_OVERRUN = 2;
    localparam int STAT_FRAME_ERR = 3;
    localparam int STAT_BAUD_FAST = 4;
    localparam int STAT_POL_STD = 5;
    localparam int STAT_ESCAPE = 6;
    localparam int STAT_LAST_LO = 8;
    localparam int STAT_LAST_HI = 15;

    localparam int FIFO_DEPTH = 2;

    typedef enum logic [1:0] {
        ST_POWERUP = 2'b10,
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_WAIT = 2'b11
    } state_type;

    typedef enum logic [1:0] {
        RX_START = 2'b00,
        RX_DATA = 2'b01,
        RX_STOP = 2'b11
    } rx_phase_type;

    typedef enum logic [2:0] {
        OP_INIT = 3'h0,
        OP_CHAR = 3'h1,
        OP_HOMECHAR = 3'h2,
        OP_CLEAR = 3'h3,
        OP_BACKSPACE = 3'h4,
        OP_CMD = 3'h5
    } op_type;
endpackage : lcd_bridge_pkg
